// file: design/sacc_adc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_adc_ctrl
  import sacc_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic [11:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                halt_mode,
  input  wire logic                comp_in,
  output logic [3:0]               chan_sel,
  output logic [RES_BITS-1:0]      dac_code,
  output logic                     sample_en,
  output logic                     adc_power_on,
  output logic                     done_irq,
  output logic                     wake_req
);

  // ==========================================================
  // declarations
  logic                  setup;
  logic                  access;
  logic                  hit_csr;
  logic                  hit_msb;
  logic                  hit_lsb;
  logic                  hit_cbc;
  logic                  mapped;
  logic                  wr_csr;
  logic                  wr_cbc;
  logic                  rd_msb;
  logic                  rd_lsb;
  logic                  lsb_setup;

  logic                  enable_reg;
  logic [1:0]            pre_reg;
  logic [3:0]            chan_reg;
  logic                  irq_en_reg;
  logic                  stretch_reg;
  logic                  done_reg;
  logic                  lock_reg;
  logic [RES_BITS-1:0]   res_reg;
  logic [31:0]           prdata_reg;
  logic [31:0]           prdata_next;

  logic                  run;
  logic                  run_d_reg;
  logic                  chan_change;
  logic                  restart;
  logic [6:0]            div_target;
  logic [6:0]            pre_cnt_reg;
  logic                  tick;
  logic                  comp_meta_reg;
  logic                  comp_sync_reg;

  logic                  core_sampling;
  logic                  core_done;
  logic [RES_BITS-1:0]   core_result;
  logic                  store_ok;

  // ==========================================================
  // apb decode
  // zero wait states: every access phase completes at once
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign hit_csr = (paddr == ADDR_CSR);
  assign hit_msb = (paddr == ADDR_MSB);
  assign hit_lsb = (paddr == ADDR_LSB);
  assign hit_cbc = (paddr == ADDR_CBC);
  assign mapped  = hit_csr | hit_msb | hit_lsb | hit_cbc;

  assign pready  = access;
  assign pslverr = access & ~mapped;

  assign wr_csr = access & pwrite & hit_csr;
  assign wr_cbc = access & pwrite & hit_cbc;
  assign rd_msb = access & ~pwrite & hit_msb;
  assign rd_lsb = access & ~pwrite & hit_lsb;

  // low byte value is captured during setup; no store may slip in
  // between that capture and the lock taking hold
  assign lsb_setup = setup & ~pwrite & hit_lsb;

  // ==========================================================
  // control/status fields
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enable_reg <= 1'b0;
      pre_reg    <= PRE_FAST;
      chan_reg   <= 4'h0;
    end else if (wr_csr) begin
      // done bit is read only; its write value is dropped
      enable_reg <= pwdata[CSR_EN_BIT];
      pre_reg    <= pwdata[CSR_PRE_MSB:CSR_PRE_LSB];
      chan_reg   <= pwdata[CSR_CH_MSB:0];
    end
  end

  // ==========================================================
  // clock/beep control bits: stretch feeds the converter, irq enable gates the interrupt
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_en_reg  <= 1'b0;
      stretch_reg <= 1'b0;
    end else if (wr_cbc) begin
      irq_en_reg  <= pwdata[CBC_IRQ_BIT];
      stretch_reg <= pwdata[CBC_STR_BIT];
    end
  end

  // ==========================================================
  // run control
  // halt powers the converter down; wait has no effect here
  assign run = enable_reg & ~halt_mode;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_d_reg <= 1'b0;
    end else begin
      run_d_reg <= run;
    end
  end

  // rewriting the same channel keeps the running conversion
  assign chan_change = wr_csr & run & (pwdata[CSR_CH_MSB:0] != chan_reg);
  assign restart     = (run & ~run_d_reg) | chan_change;

  // ==========================================================
  // converter clock prescaler
  always_comb begin
    unique case (pre_reg)
      PRE_FAST: div_target = DIV_FAST;
      PRE_MID:  div_target = DIV_MID;
      PRE_SLOW: div_target = DIV_SLOW;
      default:  div_target = DIV_SLOW;
    endcase
  end

  // restart realigns the divider so every conversion is the same length
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_cnt_reg <= 7'h00;
    end else if (!run || restart || tick) begin
      pre_cnt_reg <= 7'h00;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 7'h01;
    end
  end

  // >= so a smaller divisor written mid-count never overruns
  assign tick = run & ~restart & (pre_cnt_reg >= div_target);

  // ==========================================================
  // comparator synchroniser
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      comp_meta_reg <= comp_in;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // ==========================================================
  // successive approximation sequencer
  sacc_sar_core u_core (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .run        (run),
    .restart    (restart),
    .tick       (tick),
    .stretch    (stretch_reg),
    .comp_hi    (comp_sync_reg),
    .dac_code   (dac_code),
    .sampling   (core_sampling),
    .converting (),
    .conv_done  (core_done),
    .result     (core_result)
  );

  // ==========================================================
  // done flag
  // a finishing conversion beats a same-cycle clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else if (core_done) begin
      done_reg <= 1'b1;
    end else if (rd_msb) begin
      done_reg <= 1'b0;
    end else if (restart || !run) begin
      done_reg <= 1'b0;
    end
  end

  // ==========================================================
  // result lock
  // software must follow a low read with a high read, or results freeze
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lock_reg <= 1'b0;
    end else if (!enable_reg) begin
      lock_reg <= 1'b0;
    end else if (rd_msb) begin
      lock_reg <= 1'b0;
    end else if (rd_lsb) begin
      lock_reg <= 1'b1;
    end
  end

  // an 8-bit reader never touches the low byte, so no lock is left
  assign store_ok = core_done & ~lock_reg & ~lsb_setup & ~rd_lsb;

  // ==========================================================
  // result registers
  // held until the next completed, unlocked conversion
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      res_reg <= RST_RESULT;
    end else if (store_ok) begin
      res_reg <= core_result;
    end
  end

  // ==========================================================
  // read data
  // captured in setup so prdata is a flop during the access phase
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (hit_csr) begin
      prdata_next[CSR_DONE_BIT]            = done_reg;
      prdata_next[CSR_PRE_MSB:CSR_PRE_LSB] = pre_reg;
      prdata_next[CSR_EN_BIT]              = enable_reg;
      prdata_next[CSR_CH_MSB:0]            = chan_reg;
    end else if (hit_msb) begin
      prdata_next[7:0] = res_reg[RES_BITS-1:2];
    end else if (hit_lsb) begin
      prdata_next[1:0] = res_reg[1:0];
    end else if (hit_cbc) begin
      prdata_next[CBC_IRQ_BIT] = irq_en_reg;
      prdata_next[CBC_STR_BIT] = stretch_reg;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

  // ==========================================================
  // analog side
  assign chan_sel     = chan_reg;
  // power follows run at once; the core only idles one edge later
  assign sample_en    = core_sampling & run;
  assign adc_power_on = run;

  // ==========================================================
  // interrupt request
  // only wait can be left on this request; halt stops the converter
  assign done_irq = done_reg & irq_en_reg;
  assign wake_req = done_irq & ~halt_mode;

endmodule // sacc_adc_ctrl

`default_nettype wire

// file: design/sacc_pkg.sv
// Function
// - enable powers converter, converts continuously
// - done flag cleared when a conversion is (re)started, not by later continuous conversions
// - finished conversion sets done flag
// - done interrupt only when enabled; wakes wait
// - result stays until next conversion ends
// - high byte read clears done flag
// - new channel aborts and restarts conversion
// - low byte read locks both result registers
// - high byte read or disable unlocks
// - locked results not overwritten by conversions
// - over-range gives 3FF, under-range zero
// - 10-bit result split over two bytes
// - channel field selects one of 16
// - stretch bit lengthens sampling time
// - disable or halt powers converter down
// - control/status layout: done, prescale, enable, channel
// - prescale codes give 4, 2, 1 MHz
// - high holds bits 9:2, low bits 1:0
package sacc_pkg;

  // ==========================================================
  // clocking
  localparam int SYS_CLK_HZ    = 100_000_000;
  localparam int ADC_F_FAST_HZ = 4_000_000;
  localparam int ADC_F_MID_HZ  = 2_000_000;
  localparam int ADC_F_SLOW_HZ = 1_000_000;
  localparam logic [6:0] DIV_FAST = 7'(SYS_CLK_HZ / ADC_F_FAST_HZ - 1);
  localparam logic [6:0] DIV_MID  = 7'(SYS_CLK_HZ / ADC_F_MID_HZ - 1);
  localparam logic [6:0] DIV_SLOW = 7'(SYS_CLK_HZ / ADC_F_SLOW_HZ - 1);

  // ==========================================================
  // conversion timing in converter clocks
  localparam int RES_BITS = 10;
  localparam logic [3:0] SAMPLE_TICKS      = 4'h3;
  localparam logic [3:0] SAMPLE_TICKS_LONG = 4'h6;

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CSR = 8'h2E;
  localparam logic [7:0] IDX_MSB = 8'h2F;
  localparam logic [7:0] IDX_LSB = 8'h30;
  localparam logic [7:0] IDX_CBC = 8'h31;
  localparam logic [11:0] ADDR_CSR = {2'b00, IDX_CSR, 2'b00};
  localparam logic [11:0] ADDR_MSB = {2'b00, IDX_MSB, 2'b00};
  localparam logic [11:0] ADDR_LSB = {2'b00, IDX_LSB, 2'b00};
  localparam logic [11:0] ADDR_CBC = {2'b00, IDX_CBC, 2'b00};

  // ==========================================================
  // field positions and reset values
  localparam int CSR_DONE_BIT = 7;
  localparam int CSR_PRE_MSB  = 6;
  localparam int CSR_PRE_LSB  = 5;
  localparam int CSR_EN_BIT   = 4;
  localparam int CSR_CH_MSB   = 3;
  localparam int CBC_IRQ_BIT  = 0;
  localparam int CBC_STR_BIT  = 1;
  localparam logic [1:0] PRE_FAST = 2'h0;
  localparam logic [1:0] PRE_MID  = 2'h1;
  localparam logic [1:0] PRE_SLOW = 2'h2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [RES_BITS-1:0] RST_RESULT = 10'h000;

  typedef enum logic [2:0] {
    SACC_IDLE   = 3'b001,
    SACC_SAMPLE = 3'b010,
    SACC_STEP   = 3'b100
  } sacc_state_t;

endpackage

// file: design/sacc_sar_core.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_sar_core
  import sacc_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                run,
  input  wire logic                restart,
  input  wire logic                tick,
  input  wire logic                stretch,
  input  wire logic                comp_hi,
  output logic [RES_BITS-1:0]      dac_code,
  output logic                     sampling,
  output logic                     converting,
  output logic                     conv_done,
  output logic [RES_BITS-1:0]      result
);

  sacc_state_t           state_reg;
  logic [3:0]            samp_cnt_reg;
  logic [3:0]            bit_reg;
  logic [RES_BITS-1:0]   trial_reg;
  logic [RES_BITS-1:0]   kept;
  logic [3:0]            samp_len;

  assign samp_len = stretch ? SAMPLE_TICKS_LONG : SAMPLE_TICKS;
  // keep trial bit only if input is above the trial level
  assign kept = comp_hi ? trial_reg : (trial_reg & ~(10'h001 << bit_reg));

  // ==========================================================
  // sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg    <= SACC_IDLE;
      samp_cnt_reg <= 4'h0;
      bit_reg      <= 4'h0;
      trial_reg    <= RST_RESULT;
      conv_done    <= 1'b0;
      result       <= RST_RESULT;
    end else begin
      conv_done <= 1'b0;
      if (!run) begin
        state_reg <= SACC_IDLE;
      end else if (restart) begin
        state_reg    <= SACC_SAMPLE;
        samp_cnt_reg <= 4'h0;
      end else if (tick) begin
        unique case (state_reg)
          SACC_IDLE: begin
            state_reg    <= SACC_SAMPLE;
            samp_cnt_reg <= 4'h0;
          end
          SACC_SAMPLE: begin
            if (samp_cnt_reg + 4'h1 >= samp_len) begin
              state_reg <= SACC_STEP;
              bit_reg   <= 4'(RES_BITS - 1);
              trial_reg <= 10'h200;
            end else begin
              samp_cnt_reg <= samp_cnt_reg + 4'h1;
            end
          end
          SACC_STEP: begin
            // all-high comparisons end at 3FF, all-low at 000
            if (bit_reg == 4'h0) begin
              result       <= kept;
              conv_done    <= 1'b1;
              state_reg    <= SACC_SAMPLE;
              samp_cnt_reg <= 4'h0;
            end else begin
              trial_reg <= kept | (10'h001 << (bit_reg - 4'h1));
              bit_reg   <= bit_reg - 4'h1;
            end
          end
        endcase
      end
    end
  end

  assign dac_code   = trial_reg;
  assign sampling   = (state_reg == SACC_SAMPLE);
  assign converting = (state_reg != SACC_IDLE);

endmodule // sacc_sar_core

`default_nettype wire

// file: verification/sacc_adc_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_adc_ctrl_chk
  import sacc_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic [11:0]         paddr,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                halt_mode,
  input wire logic [3:0]          chan_sel,
  input wire logic                sample_en,
  input wire logic                adc_power_on,
  input wire logic                done_irq,
  input wire logic                wake_req
);
  // ==========================================================
  // helpers
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire acc    = psel && penable;
  wire mapped = paddr inside {ADDR_CSR, ADDR_MSB, ADDR_LSB, ADDR_CBC};
  wire csr_wr = acc && pwrite && (paddr == ADDR_CSR);

  // ==========================================================
  // assertions
  chk_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access without slave error");
  chk_mapped_ok: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  chk_halt_power: assert property (halt_mode |-> !adc_power_on)
    else $error("converter powered during halt");
  chk_wake_gate: assert property (wake_req == (done_irq && !halt_mode))
    else $error("wake request not gated by halt");
  chk_sample_power: assert property ($rose(adc_power_on) |=> sample_en)
    else $error("no sampling after power on");
  chk_chan_source: assert property ($changed(chan_sel) |-> $past(csr_wr))
    else $error("channel changed without write");
  chk_chan_value: assert property (csr_wr |=> chan_sel == $past(pwdata[3:0]))
    else $error("channel field not taken");
  chk_disable_power: assert property (csr_wr && !pwdata[4] |=> !adc_power_on)
    else $error("converter still on after disable");
  chk_rdata_hold: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
    else $error("read data moved outside a read");

  cov_done_irq: cover property (done_irq);
  cov_wake: cover property (wake_req);
  cov_unmapped: cover property (acc && !mapped);
  cov_sampling: cover property ($fell(sample_en));
endmodule // sacc_adc_ctrl_chk

bind sacc_adc_ctrl sacc_adc_ctrl_chk u_chk (
  .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode),
  .chan_sel(chan_sel), .sample_en(sample_en), .adc_power_on(adc_power_on), .done_irq(done_irq),
  .wake_req(wake_req)
);

`default_nettype wire

// file: verification/sacc_adc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_adc_ctrl_tb;
  import sacc_pkg::*;
  logic                ref_clk, rst, psel, penable, pwrite, halt_mode, comp_in, err;
  logic                pready, pslverr, sample_en, adc_power_on, done_irq, wake_req;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic [3:0]          chan_sel;
  logic [RES_BITS-1:0] dac_code;
  int                  failures, cmp_count, cyc;

  sacc_adc_ctrl u_sacc_adc_ctrl (
    .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode),
    .comp_in(comp_in), .chan_sel(chan_sel), .dac_code(dac_code), .sample_en(sample_en),
    .adc_power_on(adc_power_on), .done_irq(done_irq), .wake_req(wake_req)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;

  // ==========================================================
  // shared tasks
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    cmp(what, exp, rd);
  endtask

  // polls the flag; the poll itself costs about four cycles of slack
  task automatic wait_done;
    int t0;
    t0 = cyc;
    rd = 32'h0;
    while (rd[CSR_DONE_BIT] !== 1'b1 && cyc - t0 < 3000) bus(ADDR_CSR, 1'b0, 32'h0);
    cmp("done_flag", 32'h1, 32'(rd[CSR_DONE_BIT]));
  endtask

  task automatic timed(input logic [31:0] csr, input logic [31:0] cbc, input int lo, input int hi);
    int t0;
    bus(ADDR_CSR, 1'b1, 32'h0);
    bus(ADDR_CBC, 1'b1, cbc);
    t0 = cyc;
    bus(ADDR_CSR, 1'b1, csr);
    wait_done;
    cmp("conv_time", 32'h1, 32'(cyc - t0 >= lo && cyc - t0 <= hi));
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rdchk("csr", ADDR_CSR, 32'h0);
    rdchk("msb", ADDR_MSB, 32'h0);
    rdchk("lsb", ADDR_LSB, 32'h0);
    rdchk("cbc", ADDR_CBC, 32'h0);
    bus(ADDR_CSR, 1'b1, 32'h80);
    rdchk("csr_ro", ADDR_CSR, 32'h0);
    bus(12'hFFC, 1'b0, 32'h0);
    cmp("slverr", 32'h1, 32'(err));
    $display("test reset finished");
  endtask

  task automatic t_range;
    comp_in <= 1'b1;
    bus(ADDR_CSR, 1'b1, 32'h15);
    wait_done;
    cmp("dac_full", 32'h3FF, 32'(dac_code));
    cmp("chan_sel", 32'h5, 32'(chan_sel));
    rdchk("lsb_over", ADDR_LSB, 32'h3);
    rdchk("msb_over", ADDR_MSB, 32'hFF);
    rdchk("csr_clear", ADDR_CSR, 32'h15);
    comp_in <= 1'b0;
    wait_done;
    bus(ADDR_MSB, 1'b0, 32'h0);
    wait_done;
    rdchk("lsb_under", ADDR_LSB, 32'h0);
    rdchk("msb_under", ADDR_MSB, 32'h0);
    $display("test range finished");
  endtask

  task automatic t_lock;
    comp_in <= 1'b1;
    bus(ADDR_LSB, 1'b0, 32'h0);
    wait_done;
    rdchk("msb_locked", ADDR_MSB, 32'h0);
    wait_done;
    rdchk("lsb_free", ADDR_LSB, 32'h3);
    rdchk("msb_free", ADDR_MSB, 32'hFF);
    bus(ADDR_LSB, 1'b0, 32'h0);
    bus(ADDR_CSR, 1'b1, 32'h5);
    @(posedge ref_clk);
    cmp("power_off", 32'h0, 32'(adc_power_on));
    cmp("sample_off", 32'h0, 32'(sample_en));
    comp_in <= 1'b0;
    bus(ADDR_CSR, 1'b1, 32'h15);
    wait_done;
    rdchk("lsb_unlock", ADDR_LSB, 32'h0);
    rdchk("msb_unlock", ADDR_MSB, 32'h0);
    $display("test lock finished");
  endtask

  task automatic t_time;
    timed(32'h15, 32'h0, 300, 360);
    timed(32'h15, 32'h2, 375, 440);
    timed(32'h35, 32'h0, 620, 710);
    timed(32'h55, 32'h0, 1250, 1410);
    $display("test timing finished");
  endtask

  task automatic t_chan;
    int t0;
    bus(ADDR_CSR, 1'b1, 32'h0);
    bus(ADDR_CSR, 1'b1, 32'h15);
    repeat (200) @(posedge ref_clk);
    t0 = cyc;
    bus(ADDR_CSR, 1'b1, 32'h19);
    @(posedge ref_clk);
    cmp("chan_new", 32'h9, 32'(chan_sel));
    wait_done;
    cmp("restart_time", 32'h1, 32'(cyc - t0 >= 300 && cyc - t0 <= 360));
    $display("test channel finished");
  endtask

  task automatic t_irq;
    bus(ADDR_CSR, 1'b1, 32'h0);
    bus(ADDR_CBC, 1'b1, 32'h1);
    bus(ADDR_CSR, 1'b1, 32'h15);
    wait_done;
    cmp("done_irq", 32'h1, 32'(done_irq));
    cmp("wake_req", 32'h1, 32'(wake_req));
    halt_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    cmp("wake_halt", 32'h0, 32'(wake_req));
    cmp("power_halt", 32'h0, 32'(adc_power_on));
    halt_mode <= 1'b0;
    bus(ADDR_CBC, 1'b1, 32'h0);
    wait_done;
    cmp("irq_masked", 32'h0, 32'(done_irq));
    $display("test interrupt finished");
  endtask

  // ==========================================================
  // sequence and verdict
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    halt_mode = 1'b0; comp_in = 1'b0; failures = 0; cmp_count = 0; cyc = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_range;
    t_lock;
    t_time;
    t_chan;
    t_irq;
    close_out;
  end

  // whole run needs about six thousand cycles; wide margin for slow polls
  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    $display("watchdog expired");
    close_out;
  end
endmodule // sacc_adc_ctrl_tb

`default_nettype wire
